/* File: hw/dsac_top.sv */
// Local design decisions: the AHB-Lite slave port and the register offsets.
`include "dsac_defs.svh"
`default_nettype none

module dsac_top #(
  parameter int unsigned AW = 32
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          hsel,
  input  wire logic [AW-1:0] haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire logic          acc_req,
  input  wire logic [2:0]    acc_area,
  input  wire logic          acc_write,
  output logic               acc_ack,
  output logic [7:0]         area_select_n,
  output logic               dram_cas_n,
  output logic               col_addr_sel,
  output logic               ext_write_n
);

  localparam int CPS = `DSAC_CLK_PER_STATE;

  // Picks the kind of cycle an area gets under a space code.
  // Code 110 and areas outside 2 to 5 fall back to normal cycles, so a
  // forbidden code can never drive a memory strobe.
  function automatic dsac_pkg::dsac_kind_e kind_of(
    input logic [2:0] space,
    input logic [2:0] area
  );
    logic in25;
    in25 = (area >= 3'h2) && (area <= 3'h5);
    kind_of = dsac_pkg::DSAC_K_NORMAL;
    case (space)
      dsac_pkg::DSAC_SP_NORMAL:
        kind_of = dsac_pkg::DSAC_K_NORMAL;
      dsac_pkg::DSAC_SP_DRAM_A2:
        if (area == 3'h2)
          kind_of = dsac_pkg::DSAC_K_DRAM;
      dsac_pkg::DSAC_SP_DRAM_A23:
        if (area == 3'h2 || area == 3'h3)
          kind_of = dsac_pkg::DSAC_K_DRAM;
      dsac_pkg::DSAC_SP_DRAM_A25:
        if (in25)
          kind_of = dsac_pkg::DSAC_K_DRAM;
      dsac_pkg::DSAC_SP_CONT_DR:
        if (in25)
          kind_of = dsac_pkg::DSAC_K_DRAM;
      dsac_pkg::DSAC_SP_CONT_SD:
        if (in25)
          kind_of = dsac_pkg::DSAC_K_SDRAM;
      dsac_pkg::DSAC_SP_MODE_SET:
        if (in25)
          kind_of = dsac_pkg::DSAC_K_MRS;
      default:
        kind_of = dsac_pkg::DSAC_K_NORMAL;
    endcase
  endfunction

  // True in the last clock of a phase that lasts n bus states.
  function automatic logic phase_last(
    input logic [2:0] cnt,
    input int         n
  );
    phase_last = (cnt == 3'(n * CPS - 1));
  endfunction

  // Bus slave.
  // Writes land at the end of their data phase with no wait state.
  // A read holds hreadyout low for its first data cycle, so that the
  // selected word is captured into hrdata_q and stands while the
  // master samples it.
  logic        dph_q;
  logic        dph_wr_q;
  logic [7:0]  dph_ofs_q;
  logic        rd_rdy_q;
  logic [31:0] hrdata_q;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;

  wire         accept   = hsel & hready & htrans[1];
  wire         rd_first = dph_q & ~dph_wr_q & ~rd_rdy_q;
  wire         wr_ctrl  = dph_q & dph_wr_q &
                          (dph_ofs_q == `DSAC_CTRL_OFS);
  wire         is_ctrl  = (dph_ofs_q == `DSAC_CTRL_OFS);
  wire         is_stat  = (dph_ofs_q == `DSAC_STAT_OFS);
  wire [31:0]  stat_val;
  wire [31:0]  rd_val   = is_ctrl ? {16'h0000, ctrl_q} :
                          is_stat ? stat_val : 32'h0000_0000;

  // Bit 11 is writable like its neighbours and has no effect.
  assign ctrl_d = (ctrl_q & ~`DSAC_CTRL_WMASK) |
                  (hwdata[15:0] & `DSAC_CTRL_WMASK);

  assign hreadyout = ~rd_first;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dph_q     <= 1'b0;
      dph_wr_q  <= 1'b0;
      dph_ofs_q <= 8'h00;
    end
    else if (hreadyout)
    begin
      dph_q     <= accept;
      dph_wr_q  <= hwrite;
      dph_ofs_q <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_rdy_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end
    else if (rd_first)
    begin
      rd_rdy_q <= 1'b1;
      hrdata_q <= rd_val;
    end
    else if (hreadyout)
      rd_rdy_q <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `DSAC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= ctrl_d;
  end

  // Live configuration fields; the sequencer latches them per access.
  wire [2:0] space_sel = ctrl_q[`DSAC_SPACE_MSB:`DSAC_SPACE_LSB];
  wire       row_strobe_timing_select_cfg  = ctrl_q[`DSAC_ROWTIM_BIT];
  wire       column_cycle_length_select_cfg  = ctrl_q[`DSAC_COLLEN_BIT];

  // Access sequencer.
  dsac_pkg::dsac_state_e state_q;
  dsac_pkg::dsac_state_e state_d;
  dsac_pkg::dsac_kind_e  kind_q;
  logic [2:0]            cnt_q;
  logic [2:0]            area_q;
  logic                  write_q;
  logic                  column_cycle_length_select_q;
  logic                  row_strobe_timing_select_q;
  logic                  cont_q;

  wire dsac_pkg::dsac_kind_e new_kind =
    kind_of(space_sel, acc_area);
  wire start     = (state_q == dsac_pkg::DSAC_ST_IDLE) & acc_req;
  wire [2:0] col_n = column_cycle_length_select_q ? 3'(`DSAC_COL_LONG) :
                              3'(`DSAC_COL_SHORT);
  wire norm_end  = phase_last(cnt_q, `DSAC_NORM_STATES);
  wire row_end   = phase_last(cnt_q, `DSAC_ROW_STATES);
  wire col_end   = column_cycle_length_select_q ? phase_last(cnt_q, `DSAC_COL_LONG) :
                            phase_last(cnt_q, `DSAC_COL_SHORT);
  wire cmd_end   = phase_last(cnt_q, `DSAC_CMD_STATES);
  wire in_norm   = (state_q == dsac_pkg::DSAC_ST_NORM);
  wire in_row    = (state_q == dsac_pkg::DSAC_ST_ROW);
  wire in_col    = (state_q == dsac_pkg::DSAC_ST_COL);
  wire in_cmd    = (state_q == dsac_pkg::DSAC_ST_CMD);
  wire ph_end    = (in_norm & norm_end) | (in_row & row_end) |
                   (in_col & col_end) | (in_cmd & cmd_end);
  // With the late row strobe the pin waits for the second clock of the
  // row state, standing in for the falling edge inside it.
  wire late_half = ((cnt_q % CPS) >= (CPS / 2));
  wire busy      = (state_q != dsac_pkg::DSAC_ST_IDLE);

  assign acc_ack  = (in_norm & norm_end) | (in_col & col_end) |
                    (in_cmd & cmd_end);
  // Status word: busy in bit 0, the kind of the latched access in bits
  // 2:1 and a three-state column phase in bit 3.
  assign stat_val = {28'h0000000, col_n == 3'(`DSAC_COL_LONG),
                     kind_q, busy};

  // Normal cycles take one phase, DRAM and synchronous DRAM cycles a row
  // phase and then a column phase, mode setting a single command phase.
  // The acknowledge marks the last clock of the access.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dsac_pkg::DSAC_ST_IDLE:
        if (acc_req)
        begin
          case (new_kind)
            dsac_pkg::DSAC_K_NORMAL: state_d = dsac_pkg::DSAC_ST_NORM;
            dsac_pkg::DSAC_K_MRS:    state_d = dsac_pkg::DSAC_ST_CMD;
            default:                 state_d = dsac_pkg::DSAC_ST_ROW;
          endcase
        end
      dsac_pkg::DSAC_ST_NORM:
        if (norm_end)
          state_d = dsac_pkg::DSAC_ST_IDLE;
      dsac_pkg::DSAC_ST_ROW:
        if (row_end)
          state_d = dsac_pkg::DSAC_ST_COL;
      dsac_pkg::DSAC_ST_COL:
        if (col_end)
          state_d = dsac_pkg::DSAC_ST_IDLE;
      dsac_pkg::DSAC_ST_CMD:
        if (cmd_end)
          state_d = dsac_pkg::DSAC_ST_IDLE;
      default:
        state_d = dsac_pkg::DSAC_ST_IDLE;
    endcase
  end

  // The counter restarts at every phase boundary; in idle it runs free
  // and its value is never used.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= dsac_pkg::DSAC_ST_IDLE;
      cnt_q   <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= (start | ph_end) ? 3'h0 : cnt_q + 3'h1;
    end
  end

  // Configuration is frozen for the length of one access.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kind_q  <= dsac_pkg::DSAC_K_NORMAL;
      area_q  <= 3'h0;
      write_q <= 1'b0;
      column_cycle_length_select_q  <= 1'b0;
      row_strobe_timing_select_q  <= 1'b0;
      cont_q  <= 1'b0;
    end
    else if (start)
    begin
      kind_q  <= new_kind;
      area_q  <= acc_area;
      write_q <= acc_write;
      column_cycle_length_select_q  <= column_cycle_length_select_cfg;
      row_strobe_timing_select_q  <= row_strobe_timing_select_cfg;
      cont_q  <= (space_sel == dsac_pkg::DSAC_SP_CONT_DR);
    end
  end

  // Pin drive, active high inside and inverted at the flops, except col_addr_sel.
  // Every strobe is registered so the pins are glitch free; they trail
  // the state by one clock.
  wire       is_dram  = (kind_q == dsac_pkg::DSAC_K_DRAM);
  wire       is_sd    = (kind_q == dsac_pkg::DSAC_K_SDRAM);
  wire       ras_on   = (in_row & (row_strobe_timing_select_q | late_half)) | in_col;
  wire [2:0] ras_pin  = cont_q ? 3'h2 : area_q;
  wire [7:0] area_oh  = 8'h01 << area_q;
  wire [7:0] ras_oh   = 8'h01 << ras_pin;
  wire       sd_first = in_col & (cnt_q < 3'(CPS));
  wire       sd_ras   = (is_sd & in_row) | in_cmd;
  wire       sd_cas   = (is_sd & sd_first) | in_cmd;
  wire       sd_we    = (is_sd & sd_first & write_q) | in_cmd;
  wire [7:0] sd_oh    = {3'h0, sd_we, sd_cas, sd_ras, 2'h0};
  wire [7:0] sel_d    = in_norm ? area_oh :
                        (is_dram & ras_on) ? ras_oh : sd_oh;
  wire       cas_d    = is_dram & in_col & (cnt_q >= 3'(CPS));
  wire       colsel_d = in_col & (is_dram | is_sd);
  // Synchronous DRAM writes are signalled on the area 4 pin, not on the
  // write strobe.
  wire       wr_d     = write_q & (in_norm | (is_dram & in_col));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      area_select_n <= 8'hff;
      dram_cas_n    <= 1'b1;
      col_addr_sel  <= 1'b0;
      ext_write_n   <= 1'b1;
    end
    else
    begin
      area_select_n <= ~sel_d;
      dram_cas_n    <= ~cas_d;
      col_addr_sel  <= colsel_d;
      ext_write_n   <= ~wr_d;
    end
  end

endmodule // dsac_top

`default_nettype wire

/* File: include/dsac_defs.svh */
// Notes on behaviour
// - DRAM column output lasts 2 states with its length bit 0, else 3.
// - Space code 000 leaves areas 2 to 5 normal; 001 makes area 2 DRAM.
// - Space code 010 makes areas 2 and 3 DRAM and areas 4 and 5 normal.
// - Space code 011 makes each of areas 2 to 5 a separate DRAM space.
// - Space code 111 makes areas 2 to 5 one continuous DRAM space.
// - Continuous DRAM space drives its row strobe on the area 2 pin.
// - Space code 100 makes areas 2 to 5 continuous synchronous DRAM space.
// - In it row strobe, column strobe, write enable use area pins 2 to 4.
// - Code 101 runs synchronous DRAM mode setting; 110 is never written.
// - Row strobe starts with the row cycle if its bit is 1, else mid-cycle.
`ifndef DSAC_DEFS_SVH
`define DSAC_DEFS_SVH

`define DSAC_CTRL_OFS      8'h00
`define DSAC_STAT_OFS      8'h04
`define DSAC_CTRL_RST      16'h0000
`define DSAC_CTRL_WMASK    16'h7f00
`define DSAC_ROWTIM_BIT    14
`define DSAC_COLLEN_BIT    12
`define DSAC_RSV11_BIT     11
`define DSAC_SPACE_MSB     10
`define DSAC_SPACE_LSB     8
`define DSAC_CLK_PER_STATE 2
`define DSAC_NORM_STATES   2
`define DSAC_ROW_STATES    1
`define DSAC_COL_SHORT     2
`define DSAC_COL_LONG      3
`define DSAC_CMD_STATES    1

`endif

/* File: include/dsac_pkg.sv */
`default_nettype none
package dsac_pkg;

  typedef enum logic [2:0] {
    DSAC_SP_NORMAL   = 3'h0,
    DSAC_SP_DRAM_A2  = 3'h1,
    DSAC_SP_DRAM_A23 = 3'h2,
    DSAC_SP_DRAM_A25 = 3'h3,
    DSAC_SP_CONT_SD  = 3'h4,
    DSAC_SP_MODE_SET = 3'h5,
    DSAC_SP_BAD      = 3'h6,
    DSAC_SP_CONT_DR  = 3'h7
  } dsac_space_e;

  typedef enum logic [1:0] {
    DSAC_K_NORMAL = 2'h0,
    DSAC_K_DRAM   = 2'h1,
    DSAC_K_SDRAM  = 2'h2,
    DSAC_K_MRS    = 2'h3
  } dsac_kind_e;

  typedef enum logic [4:0] {
    DSAC_ST_IDLE = 5'h01,
    DSAC_ST_NORM = 5'h02,
    DSAC_ST_ROW  = 5'h04,
    DSAC_ST_COL  = 5'h08,
    DSAC_ST_CMD  = 5'h10
  } dsac_state_e;

endpackage
`default_nettype wire

/* File: dv/dsac_properties.sv */
`default_nettype none
module dsac_properties #(
  parameter int unsigned AW = 32
) (
  input wire logic          core_clk,
  input wire logic          rst_n,
  input wire logic          hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic          acc_req,
  input wire logic [2:0]    acc_area,
  input wire logic          acc_write,
  input wire logic          acc_ack,
  input wire logic [7:0]    area_select_n,
  input wire logic          col_addr_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of the control fields, and whether an access is running.
  logic            wp_q, busy_q;
  logic [6:0]      cr_q;
  wire logic       st = acc_req && !busy_q;
  wire logic       ar = acc_area >= 3'h2 && acc_area <= 3'h5;
  wire logic [2:0] sp = cr_q[2:0];
  wire logic [2:0] rp = sp == 3'h7 ? 3'h2 : acc_area;
  wire logic       sd = ar && sp == 3'h4;
  wire logic       mr = ar && sp == 3'h5;
  wire logic       dr = ar && (sp == 3'h3 || sp == 3'h7 ||
    (sp == 3'h1 && acc_area == 3'h2) || (sp == 3'h2 && acc_area < 3'h4));
  wire logic       nm = !(dr || sd || mr);
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      wp_q   <= 1'b0;
      busy_q <= 1'b0;
      cr_q   <= 7'h00;
    end
    else
    begin
      wp_q   <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      busy_q <= st || (busy_q && !acc_ack);
      if (wp_q)
        cr_q <= hwdata[14:8];
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_norm_len: assert property (
    st && nm |=> (!acc_ack)[*3] ##1 acc_ack) else $error("normal length");
  a_col_short: assert property (
    st && (dr || sd) && !cr_q[4] |=> (!acc_ack)[*5] ##1 acc_ack)
    else $error("short column");
  a_col_addr: assert property (
    st && dr |-> ##4 col_addr_sel[*4] ##1 col_addr_sel == cr_q[4])
    else $error("column address length");
  a_row_early: assert property (
    st && dr && cr_q[6] |-> ##2 !area_select_n[rp]) else $error("row early");
  a_row_late: assert property (
    st && dr && !cr_q[6] |-> ##2 area_select_n[rp] ##1 !area_select_n[rp])
    else $error("row late");
  a_cont_row: assert property (
    st && dr && sp == 3'h7 |-> ##3 (!area_select_n[2])[*5])
    else $error("row pin");
  a_sd_pins: assert property (
    st && sd |-> ##2 !area_select_n[2] ##2 !area_select_n[3] &&
    area_select_n[4] == !acc_write) else $error("sdram pins");
  a_mode_set: assert property (
    st && mr |=> !acc_ack ##1 acc_ack && area_select_n[4:2] == 3'h0)
    else $error("mode set");
endmodule // dsac_properties
bind dsac_top dsac_properties #(.AW(AW)) i_dsac_properties (
  .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .acc_req, .acc_area, .acc_write, .acc_ack, .area_select_n, .col_addr_sel);
`default_nettype wire

/* File: dv/dsac_mem_model.sv */
`default_nettype none
module dsac_mem_model (
  input wire logic       core_clk,
  input wire logic       clr,
  input wire logic [7:0] area_select_n,
  input wire logic       dram_cas_n,
  input wire logic       col_addr_sel,
  input wire logic       ext_write_n,
  output logic [7:0]     pins_seen,
  output logic [3:0]     col_clks,
  output logic [3:0]     cas_clks,
  output logic           wr_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // The memory side notes every select pin it saw driven low since clr,
  // counts the clocks of column address and column strobe, and notes
  // any write strobe.
  always @(posedge core_clk)
  begin
    pins_seen <= clr ? 8'h00 : pins_seen | ~area_select_n;
    col_clks  <= clr ? 4'h0 : col_clks + 4'(col_addr_sel);
    cas_clks  <= clr ? 4'h0 : cas_clks + 4'(!dram_cas_n);
    wr_seen   <= clr ? 1'b0 : wr_seen | !ext_write_n;
  end
endmodule // dsac_mem_model
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hready;
  logic        acc_req = 1'b0, acc_write = 1'b0, acc_ack, clr = 1'b0;
  logic        hresp, dram_cas_n, col_addr_sel, ext_write_n, wr_seen;
  logic [3:0]  col_clks, cas_clks;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  acc_area = 3'h0;
  logic [7:0]  area_select_n, pins_seen;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  int          miscompares = 0, num_checks = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  dsac_top i_dsac_top (
    .core_clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .acc_req,
    .acc_area, .acc_write, .acc_ack, .area_select_n, .dram_cas_n,
    .col_addr_sel, .ext_write_n);
  dsac_mem_model i_dsac_mem_model (
    .core_clk, .clr, .area_select_n, .dram_cas_n, .col_addr_sel,
    .ext_write_n, .pins_seen, .col_clks, .cas_clks, .wr_seen);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    miscompares += int'(got !== exp);
    if (got !== exp)
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic finish_test(input int extra);
    miscompares += extra;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(negedge core_clk); while (hready !== 1'b1);
    @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge core_clk); while (hready !== 1'b1);
    r = hrdata;
    @(posedge core_clk);
  endtask
  // Counts clocks up to the acknowledge, then lets the lagging pins
  // settle before the memory side's record is read.
  task automatic acc(input logic [2:0] a, input logic w, output int n);
    n = 0;
    acc_req <= 1'b1;
    acc_area <= a;
    acc_write <= w;
    clr <= 1'b1;
    do
    begin
      @(negedge core_clk);
      n++;
      if (n == 2)
        clr <= 1'b0;
    end
    while (acc_ack !== 1'b1);
    @(posedge core_clk);
    acc_req <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // Gives the cycle kind, the access length in clocks and the select
  // pins seen low.
  function automatic logic [13:0] exp_of(input logic [2:0] c, a,
                                         input logic w, col);
    logic ar, dr, sd, mr;
    ar = a >= 3'h2 && a <= 3'h5;
    dr = ar && (c == 3'h3 || c == 3'h7 || (c == 3'h1 && a == 3'h2) ||
         (c == 3'h2 && a < 3'h4));
    sd = ar && c == 3'h4;
    mr = ar && c == 3'h5;
    return {mr ? 2'h3 : sd ? 2'h2 : dr ? 2'h1 : 2'h0,
            mr ? 4'h2 : (dr || sd) ? (col ? 4'h8 : 4'h6) : 4'h4,
            mr ? 8'h1c : sd ? {3'h0, w, 4'hc} :
            8'h01 << (c == 3'h7 && dr ? 3'h2 : a)};
  endfunction
  initial
  begin
    logic [31:0] r, cv;
    logic [13:0] e;
    logic [3:0]  cl;
    int          n;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    ahb(8'h00, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    ahb(8'h00, 1'b1, 32'hffff_d7ff, r);
    ahb(8'h00, 1'b0, 32'h0, r);
    chk(r, 32'h5700);
    ahb(8'h08, 1'b1, 32'h0700, r);
    ahb(8'h08, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    for (int c = 0; c < 8; c += (c == 5) ? 2 : 1)
      for (int a = 1; a < 7; a++)
      begin
        cv = {17'h0, a[2], 1'b0, a[0], 1'b0, c[2:0], 8'h00};
        ahb(8'h00, 1'b1, cv, r);
        ahb(8'h00, 1'b0, 32'h0, r);
        chk(r, cv);
        acc(a[2:0], a[1], n);
        e = exp_of(c[2:0], a[2:0], a[1], a[0]);
        chk(32'(n), {28'h0, e[11:8]} + 32'h1);
        chk({24'h0, pins_seen}, {24'h0, e[7:0]});
        cl = e[13] ^ e[12] ? (a[0] ? 4'h6 : 4'h4) : 4'h0;
        chk({28'h0, col_clks}, {28'h0, cl});
        cl = e[13:12] == 2'h1 ? (a[0] ? 4'h4 : 4'h2) : 4'h0;
        chk({28'h0, cas_clks}, {28'h0, cl});
        chk({31'h0, wr_seen}, {31'h0, a[1] & ~e[13]});
        ahb(8'h04, 1'b0, 32'h0, r);
        chk(r, {28'h0, a[0], e[13:12], 1'b0});
      end
    chk({31'h0, hresp}, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({24'h0, area_select_n}, 32'hff);
    rst_n <= 1'b1;
    ahb(8'h00, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    finish_test(0);
  end
  always @(posedge core_clk)
    if (++cyc == 4000)
      finish_test(1);
endmodule // testbench
`default_nettype wire
